// ---- src/embc_top.sv ----
module embc_top (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        boot_width_select,
  input  wire logic        ext_wait_in_n,
  input  wire logic        per_sel,
  input  wire logic        per_write,
  input  wire logic [7:0]  per_addr,
  input  wire logic [7:0]  per_wdata,
  output logic      [7:0]  per_rdata,
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic        acc_half,
  input  wire logic [31:0] acc_addr,
  output logic             acc_done,
  output logic      [1:0]  static_cs_n,
  output logic      [1:0]  ras_n,
  output logic             read_n,
  output logic      [23:0] ext_addr,
  output logic             data_bus16,
  output logic             static_we_lower_n,
  output logic             static_upper_n,
  output logic             static_lower_a0,
  output logic             dram_we_lower_n,
  output logic             dram_upper_n,
  output logic             dram_cas_lower_n
);
  logic [7:0]  bank_bus_width;
  logic [7:0]  wait_input_enable;
  logic [7:0]  bank_off_time;
  logic [7:0]  static_bank_wait;
  logic [7:0]  static_strobe_style;
  logic [7:0]  dram_lo_bank_ctrl;
  logic [7:0]  dram_hi_bank_ctrl;
  logic [7:0]  rdata_r;
  logic        strap_lvl;
  logic        wait_lvl_n;
  logic        wait_act;
  logic        reg_wr;
  embc_pkg::embc_state_e state_r;
  embc_pkg::embc_state_e state_nxt;
  logic [2:0]  cnt_r;
  logic [1:0]  cur_bank_r;
  logic        cur_int_r;
  logic        cur_write_r;
  logic        cur_half_r;
  logic [23:0] cur_addr_r;
  logic [23:0] cur_row_r;
  logic        cur_w16_r;
  logic        cur_wen_r;
  logic        cur_sstyle_r;
  logic [3:0]  cur_dctl_r;
  logic [2:0]  cur_pw_r;
  logic        last_valid_r;
  logic [1:0]  last_bank_r;
  logic        last_read_r;
  logic        page_open_r;
  logic        page_bank_r;
  logic [23:0] page_row_r;
  logic [1:0]  acc_bank;
  logic        acc_int;
  logic        acc_dram;
  logic [3:0]  dctl_sel;
  logic [23:0] row_sel;
  logic        page_hit;
  logic [2:0]  pw_start;
  logic [1:0]  off_sel;
  logic        pause;
  logic        start;
  logic        ext_active;
  logic        cur_dram;
  logic        row_phase;
  logic        col;
  logic        lane_lo;
  logic        lane_hi;

  // Pin inputs pass the three-stage filter
  embc_sync u_strap (
    .clock  (clock),
    .resetn (resetn),
    .din    (boot_width_select),
    .dout   (strap_lvl)
  );
  embc_sync u_wait (
    .clock  (clock),
    .resetn (resetn),
    .din    (ext_wait_in_n),
    .dout   (wait_lvl_n)
  );
  assign wait_act = !wait_lvl_n;
  assign reg_wr   = per_sel && per_write;

  // Row address for a given row shift select
  function automatic logic [23:0] row_of(input logic [23:0] a, input logic [1:0] sh);
    row_of = a >> (embc_pkg::ROW_SHIFT_BASE + {3'h0, sh});
  endfunction

  // strap level loads bank 0 width
  always_ff @(posedge clock) begin
    if (!resetn) begin
      bank_bus_width <= {embc_pkg::RST_WIDTH_UPPER, strap_lvl};
    end else if (reg_wr && per_addr == embc_pkg::OFS_BUS_WIDTH) begin
      bank_bus_width <= per_wdata & embc_pkg::MSK_WIDTH;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wait_input_enable   <= embc_pkg::RST_WAIT_IN;
      bank_off_time       <= embc_pkg::RST_OFF_TIME;
      static_bank_wait    <= embc_pkg::RST_STATIC_WAIT;
      static_strobe_style <= embc_pkg::RST_STROBE;
      dram_lo_bank_ctrl   <= embc_pkg::RST_DRAM;
      dram_hi_bank_ctrl   <= embc_pkg::RST_DRAM;
    end else if (reg_wr) begin
      unique case (per_addr)
        embc_pkg::OFS_WAIT_IN:     wait_input_enable   <= per_wdata & embc_pkg::MSK_WAIT_IN;
        embc_pkg::OFS_OFF_TIME:    bank_off_time       <= per_wdata & embc_pkg::MSK_OFF_TIME;
        embc_pkg::OFS_STATIC_WAIT: static_bank_wait    <= per_wdata & embc_pkg::MSK_STATIC_WAIT;
        embc_pkg::OFS_STROBE:      static_strobe_style <= per_wdata & embc_pkg::MSK_STROBE;
        embc_pkg::OFS_DRAM_LO:     dram_lo_bank_ctrl   <= per_wdata & embc_pkg::MSK_DRAM;
        embc_pkg::OFS_DRAM_HI:     dram_hi_bank_ctrl   <= per_wdata & embc_pkg::MSK_DRAM;
        default: ;
      endcase
    end
  end

  // Read data registered on a read; unmapped offsets read zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (per_sel && !per_write) begin
      unique case (per_addr)
        embc_pkg::OFS_BUS_WIDTH:   rdata_r <= bank_bus_width;
        embc_pkg::OFS_WAIT_IN:     rdata_r <= wait_input_enable;
        embc_pkg::OFS_OFF_TIME:    rdata_r <= bank_off_time;
        embc_pkg::OFS_STATIC_WAIT: rdata_r <= static_bank_wait;
        embc_pkg::OFS_STROBE:      rdata_r <= static_strobe_style;
        embc_pkg::OFS_DRAM_LO:     rdata_r <= dram_lo_bank_ctrl;
        embc_pkg::OFS_DRAM_HI:     rdata_r <= dram_hi_bank_ctrl;
        default:                   rdata_r <= 8'h00;
      endcase
    end
  end
  assign per_rdata = rdata_r;

  // bank from top two of 26 address bits
  assign acc_bank = acc_addr[embc_pkg::BANK_MSB:embc_pkg::BANK_LSB];
  assign acc_dram = acc_bank[1];
  // on-chip regions of bank 0 get no waits
  assign acc_int  = (acc_bank == embc_pkg::BANK_S0)
                 && (acc_addr[embc_pkg::REGION_MSB:embc_pkg::REGION_LSB] >= embc_pkg::INT_REG_LO)
                 && (acc_addr[embc_pkg::REGION_MSB:embc_pkg::REGION_LSB] <= embc_pkg::INT_REG_HI);
  assign dctl_sel = acc_bank[0] ? dram_hi_bank_ctrl[3:0] : dram_lo_bank_ctrl[3:0];
  // row shift select feeds the address mux
  assign row_sel  = row_of(acc_addr[23:0], dctl_sel[embc_pkg::DR_SHIFT_LSB +: 2]);
  assign page_hit = page_open_r && acc_dram && (page_bank_r == acc_bank[0])
                 && (page_row_r == row_sel) && dctl_sel[embc_pkg::DR_BURST_BIT];

  always_comb begin
    pw_start = embc_pkg::CNT_ZERO;
    if (acc_int) begin
      pw_start = embc_pkg::CNT_ZERO;
    end else if (acc_bank == embc_pkg::BANK_S0) begin
      pw_start = static_bank_wait[embc_pkg::PW0_LSB +: 3];
    end else if (acc_bank == embc_pkg::BANK_S1) begin
      pw_start = static_bank_wait[embc_pkg::PW1_LSB +: 3];
    end else if (!page_hit) begin
      pw_start = embc_pkg::DRAM_MISS_CYC;
    end
  end

  // off time field of the bank last used
  assign off_sel = bank_off_time[{last_bank_r, 1'b0} +: 2];
  // pause on bank change or read then write
  assign pause   = last_valid_r && !acc_int && (off_sel != 2'h0)
                && ((last_bank_r != acc_bank) || (last_read_r && acc_write));
  assign start   = (state_r == embc_pkg::ST_IDLE) && acc_req;

  // wait input only counts when enabled
  always_comb begin
    state_nxt = state_r;
    acc_done  = 1'b0;
    unique case (state_r)
      embc_pkg::ST_IDLE: begin
        if (acc_req) begin
          state_nxt = pause ? embc_pkg::ST_OFF : embc_pkg::ST_ACC;
        end
      end
      embc_pkg::ST_OFF: begin
        if (cnt_r == embc_pkg::CNT_ONE) begin
          state_nxt = embc_pkg::ST_ACC;
        end
      end
      embc_pkg::ST_ACC: begin
        if (cnt_r == embc_pkg::CNT_ZERO) begin
          if (cur_wen_r && wait_act) begin
            state_nxt = embc_pkg::ST_XWAIT;
          end else begin
            state_nxt = embc_pkg::ST_IDLE;
            acc_done  = 1'b1;
          end
        end
      end
      embc_pkg::ST_XWAIT: begin
        if (!wait_act) begin
          state_nxt = embc_pkg::ST_IDLE;
          acc_done  = 1'b1;
        end
      end
    endcase
  end

  // Sequencer state and shared off/wait counter
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= embc_pkg::ST_IDLE;
      cnt_r   <= embc_pkg::CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        cnt_r <= pause ? {1'b0, off_sel} : pw_start;
      end else if (state_r == embc_pkg::ST_OFF && cnt_r == embc_pkg::CNT_ONE) begin
        cnt_r <= cur_pw_r;
      end else if (state_r != embc_pkg::ST_IDLE && cnt_r != embc_pkg::CNT_ZERO) begin
        cnt_r <= cnt_r - embc_pkg::CNT_ONE;
      end
    end
  end

  // bank setup latched only when an access starts
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cur_bank_r   <= embc_pkg::BANK_S0;
      cur_int_r    <= 1'b0;
      cur_write_r  <= 1'b0;
      cur_half_r   <= 1'b0;
      cur_addr_r   <= 24'h000000;
      cur_row_r    <= 24'h000000;
      cur_w16_r    <= 1'b0;
      cur_wen_r    <= 1'b0;
      cur_sstyle_r <= 1'b0;
      cur_dctl_r   <= 4'h0;
      cur_pw_r     <= embc_pkg::CNT_ZERO;
    end else if (start) begin
      cur_bank_r   <= acc_bank;
      cur_int_r    <= acc_int;
      cur_write_r  <= acc_write;
      cur_half_r   <= acc_half;
      cur_addr_r   <= acc_addr[23:0];
      cur_row_r    <= row_sel;
      cur_w16_r    <= bank_bus_width[acc_bank];
      cur_wen_r    <= wait_input_enable[acc_bank] && !acc_int;
      cur_sstyle_r <= acc_bank[0] ? static_strobe_style[embc_pkg::STYLE1_BIT]
                                  : static_strobe_style[embc_pkg::STYLE0_BIT];
      cur_dctl_r   <= dctl_sel;
      cur_pw_r     <= pw_start;
    end
  end

  // History for off time; on-chip accesses leave it alone
  always_ff @(posedge clock) begin
    if (!resetn) begin
      last_valid_r <= 1'b0;
      last_bank_r  <= embc_pkg::BANK_S0;
      last_read_r  <= 1'b0;
    end else if (acc_done && !cur_int_r) begin
      last_valid_r <= 1'b1;
      last_bank_r  <= cur_bank_r;
      last_read_r  <= !cur_write_r;
    end
  end

  // burst keeps the row open, random closes it
  always_ff @(posedge clock) begin
    if (!resetn) begin
      page_open_r <= 1'b0;
      page_bank_r <= 1'b0;
      page_row_r  <= 24'h000000;
    end else if (start && !acc_int) begin
      page_open_r <= 1'b0;
    end else if (acc_done && !cur_int_r) begin
      page_open_r <= cur_dram && cur_dctl_r[embc_pkg::DR_BURST_BIT];
      page_bank_r <= cur_bank_r[0];
      page_row_r  <= cur_row_r;
    end
  end

  assign ext_active = (state_r == embc_pkg::ST_ACC || state_r == embc_pkg::ST_XWAIT)
                   && !cur_int_r;
  assign cur_dram   = cur_bank_r[1];
  assign row_phase  = (state_r == embc_pkg::ST_ACC) && cur_dram && (cnt_r != embc_pkg::CNT_ZERO);
  assign col        = ext_active && cur_dram && !row_phase;
  // 8-bit bank uses the low lane only
  assign lane_lo    = !cur_w16_r || cur_half_r || !cur_addr_r[0];
  assign lane_hi    = cur_w16_r && (cur_half_r || cur_addr_r[0]);

  // Shared strobes; registered, so pins trail the state by a cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      static_cs_n <= 2'h3;
      ras_n       <= 2'h3;
      read_n      <= 1'b1;
      ext_addr    <= 24'h000000;
      data_bus16  <= 1'b0;
    end else begin
      static_cs_n[0] <= !(ext_active && cur_bank_r == embc_pkg::BANK_S0);
      static_cs_n[1] <= !(ext_active && cur_bank_r == embc_pkg::BANK_S1);
      for (int j = 0; j < 2; j++) begin
        ras_n[j] <= !((ext_active && cur_dram && cur_bank_r[0] == j[0]
                       && !(state_r == embc_pkg::ST_ACC && cnt_r == embc_pkg::DRAM_MISS_CYC))
                   || (page_open_r && page_bank_r == j[0]
                       && (state_r == embc_pkg::ST_IDLE || cur_int_r)));
      end
      read_n     <= !(ext_active && !cur_write_r);
      ext_addr   <= row_phase ? cur_row_r : cur_addr_r;
      data_bus16 <= ext_active && cur_w16_r;
    end
  end

  // static pin functions by strobe style
  // DRAM pin functions by strobe style
  always_ff @(posedge clock) begin
    if (!resetn) begin
      static_we_lower_n <= 1'b1;
      static_upper_n    <= 1'b1;
      static_lower_a0   <= 1'b1;
      dram_we_lower_n   <= 1'b1;
      dram_upper_n      <= 1'b1;
      dram_cas_lower_n  <= 1'b1;
    end else begin
      if (cur_sstyle_r) begin
        static_we_lower_n <= !(ext_active && !cur_dram && cur_write_r);
        static_upper_n    <= !(ext_active && !cur_dram && lane_hi);
        static_lower_a0   <= !(ext_active && !cur_dram && lane_lo);
      end else begin
        static_we_lower_n <= !(ext_active && !cur_dram && cur_write_r && lane_lo);
        static_upper_n    <= !(ext_active && !cur_dram && cur_write_r && lane_hi);
        static_lower_a0   <= cur_addr_r[0];
      end
      if (cur_dctl_r[embc_pkg::DR_STYLE_BIT]) begin
        dram_we_lower_n  <= !(col && cur_write_r && lane_lo);
        dram_upper_n     <= !(col && cur_write_r && lane_hi);
        dram_cas_lower_n <= !col;
      end else begin
        dram_we_lower_n  <= !(col && cur_write_r);
        dram_upper_n     <= !(col && lane_hi);
        dram_cas_lower_n <= !(col && lane_lo);
      end
    end
  end

  // Checks; off time of three gives three pause cycles
  sequence s_pause3;
    (state_r == embc_pkg::ST_OFF) [*3] ##1 (state_r == embc_pkg::ST_ACC);
  endsequence
  sequence s_acc8;
    (state_r == embc_pkg::ST_ACC) [*8];
  endsequence

  // Strap filter needs several reset edges before its level is valid
  property p_reset_width;
    @(posedge clock) (!resetn && $past(!resetn, 5))
      |=> (bank_bus_width == {embc_pkg::RST_WIDTH_UPPER, $past(strap_lvl)});
  endproperty
  a_reset_width: assert property (p_reset_width) else $error("width reset wrong");
  property p_width_write;
    @(posedge clock) disable iff (!resetn)
      (reg_wr && per_addr == embc_pkg::OFS_BUS_WIDTH) |=> bank_bus_width[0] == $past(per_wdata[0]);
  endproperty
  a_width_write: assert property (p_width_write) else $error("bank 0 width not written");
  property p_reserved;
    @(posedge clock) disable iff (!resetn)
      (per_sel && !per_write && per_addr == embc_pkg::OFS_STATIC_WAIT) |=> !per_rdata[7] && !per_rdata[3];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit reads one");
  property p_wait_ignored;
    @(posedge clock) disable iff (!resetn)
      (state_r == embc_pkg::ST_ACC && cnt_r == embc_pkg::CNT_ZERO && !cur_wen_r) |-> acc_done;
  endproperty
  a_wait_ignored: assert property (p_wait_ignored) else $error("disabled wait stalled");
  property p_wait_hold;
    @(posedge clock) disable iff (!resetn)
      (state_r == embc_pkg::ST_XWAIT && wait_act) |-> !acc_done ##1 state_r == embc_pkg::ST_XWAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait not honoured");
  property p_off3;
    @(posedge clock) disable iff (!resetn) (start && pause && off_sel == 2'h3) |=> s_pause3;
  endproperty
  a_off3: assert property (p_off3) else $error("off time length wrong");
  property p_pw7;
    @(posedge clock) disable iff (!resetn)
      (state_r == embc_pkg::ST_ACC && $past(state_r) != embc_pkg::ST_ACC && cnt_r == 3'h7) |-> s_acc8;
  endproperty
  a_pw7: assert property (p_pw7) else $error("wait count length wrong");
  property p_internal;
    @(posedge clock) disable iff (!resetn) (start && acc_int && !pause) |=> acc_done;
  endproperty
  a_internal: assert property (p_internal) else $error("on-chip access delayed");
  property p_cfg_stable;
    @(posedge clock) disable iff (!resetn)
      (state_r != embc_pkg::ST_IDLE) |=> $stable(cur_w16_r) && $stable(cur_sstyle_r) && $stable(cur_pw_r);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("setup changed mid access");
  property p_bank_sel;
    @(posedge clock) disable iff (!resetn)
      (ext_active && cur_bank_r == embc_pkg::BANK_S1) |=> !static_cs_n[1] && static_cs_n[0];
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("wrong chip select");
  property p_random;
    @(posedge clock) disable iff (!resetn)
      (start && !pause && acc_dram && !dctl_sel[embc_pkg::DR_BURST_BIT]) |=> cnt_r == embc_pkg::DRAM_MISS_CYC;
  endproperty
  a_random: assert property (p_random) else $error("random access skipped row");
endmodule

// ---- src/embc_pkg.sv ----
package embc_pkg;
  // Register byte offsets within the controller block
  localparam logic [7:0] OFS_BUS_WIDTH   = 8'h00;
  localparam logic [7:0] OFS_WAIT_IN     = 8'h04;
  localparam logic [7:0] OFS_OFF_TIME    = 8'h08;
  localparam logic [7:0] OFS_STATIC_WAIT = 8'h0c;
  localparam logic [7:0] OFS_STROBE      = 8'h10;
  localparam logic [7:0] OFS_DRAM_LO     = 8'h14;
  localparam logic [7:0] OFS_DRAM_HI     = 8'h20;

  // Reset values; bank 0 width bit comes from the strap
  localparam logic [6:0] RST_WIDTH_UPPER = 7'h07;
  localparam logic [7:0] RST_WAIT_IN     = 8'h00;
  localparam logic [7:0] RST_OFF_TIME    = 8'hff;
  localparam logic [7:0] RST_STATIC_WAIT = 8'h77;
  localparam logic [7:0] RST_STROBE      = 8'h00;
  localparam logic [7:0] RST_DRAM        = 8'h00;

  // Implemented bits per register
  localparam logic [7:0] MSK_WIDTH       = 8'h0f;
  localparam logic [7:0] MSK_WAIT_IN     = 8'h0f;
  localparam logic [7:0] MSK_OFF_TIME    = 8'hff;
  localparam logic [7:0] MSK_STATIC_WAIT = 8'h77;
  localparam logic [7:0] MSK_STROBE      = 8'h11;
  localparam logic [7:0] MSK_DRAM        = 8'h0f;

  // Field positions
  localparam int PW0_LSB      = 0;
  localparam int PW1_LSB      = 4;
  localparam int STYLE0_BIT   = 0;
  localparam int STYLE1_BIT   = 4;
  localparam int DR_BURST_BIT = 0;
  localparam int DR_STYLE_BIT = 1;
  localparam int DR_SHIFT_LSB = 2;
  localparam int BANK_MSB     = 25;
  localparam int BANK_LSB     = 24;
  localparam int REGION_MSB   = 23;
  localparam int REGION_LSB   = 21;

  // Banks and bank 0 on-chip regions (2 MB granules 1..3)
  localparam logic [1:0] BANK_S0    = 2'h0;
  localparam logic [1:0] BANK_S1    = 2'h1;
  localparam logic [2:0] INT_REG_LO = 3'h1;
  localparam logic [2:0] INT_REG_HI = 3'h3;

  // Row shift base and DRAM miss cycles (precharge, row)
  localparam logic [4:0] ROW_SHIFT_BASE = 5'h08;
  localparam logic [2:0] DRAM_MISS_CYC  = 3'h2;
  localparam logic [2:0] CNT_ONE        = 3'h1;
  localparam logic [2:0] CNT_ZERO       = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_OFF   = 2'b01,
    ST_ACC   = 2'b11,
    ST_XWAIT = 2'b10
  } embc_state_e;
endpackage

// ---- src/embc_sync.sv ----
module embc_sync (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic dout_r;

  // Raw stages unreset so a strap level is seen while reset is held
  always_ff @(posedge clock) begin
    s1_r <= din;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // Accept a change only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dout_r <= s3_r;
    end else if (s2_r == s3_r) begin
      dout_r <= s3_r;
    end
  end

  assign dout = dout_r;
endmodule

// ---- tb/embc_ext_dev.sv ----
module embc_ext_dev (
  input  wire logic       clock,
  input  wire logic [1:0] static_cs_n,
  input  wire logic [7:0] stall_len,
  output logic            ext_wait_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r = 8'h00;

  // Cycles since chip select fell; saturates so a long stall cannot wrap
  always @(posedge clock) begin
    if (static_cs_n == 2'h3) begin
      cnt_r <= 8'h00;
    end else if (cnt_r != 8'hff) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign ext_wait_in_n = !((static_cs_n != 2'h3) && (cnt_r < stall_len)); // Pull-up when idle
endmodule

// ---- tb/ext_memory_bank_config_tb_top.sv ----
module ext_memory_bank_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, resetn, strap, per_sel, per_write, acc_req, acc_write, acc_half;
  logic [7:0]  per_addr, per_wdata, per_rdata, stall_len, d;
  logic [31:0] acc_addr;
  logic        acc_done, wait_n, data_bus16, we_n, up_n, a0;
  logic [1:0]  cs_n, ras_n;
  logic        read_n, rowgot;
  logic [2:0]  dpins;
  logic [3:0]  dsnap;
  logic [23:0] ext_a, row_a;
  logic [3:0]  snap;
  int          bad_count = 0, tests_run = 0, cyc = 0, e;
  integer      seed = 32'hef5faa5c;
  int          rd_q[$], acc_q[$];
  logic        rd_pend = 1'b0;
  logic [7:0]  ofs [7] = '{embc_pkg::OFS_BUS_WIDTH, embc_pkg::OFS_WAIT_IN,
    embc_pkg::OFS_OFF_TIME, embc_pkg::OFS_STATIC_WAIT, embc_pkg::OFS_STROBE,
    embc_pkg::OFS_DRAM_LO, embc_pkg::OFS_DRAM_HI};
  logic [7:0]  rst [7] = '{8'h0f, 8'h00, 8'hff, 8'h77, 8'h00, 8'h00, 8'h00};
  logic [7:0]  msk [7] = '{embc_pkg::MSK_WIDTH, embc_pkg::MSK_WAIT_IN, embc_pkg::MSK_OFF_TIME,
    embc_pkg::MSK_STATIC_WAIT, embc_pkg::MSK_STROBE, embc_pkg::MSK_DRAM, embc_pkg::MSK_DRAM};

  embc_top dut (.clock(clock), .resetn(resetn), .boot_width_select(strap),
    .ext_wait_in_n(wait_n), .per_sel(per_sel), .per_write(per_write), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_rdata(per_rdata), .acc_req(acc_req), .acc_write(acc_write),
    .acc_half(acc_half), .acc_addr(acc_addr), .acc_done(acc_done), .static_cs_n(cs_n),
    .ras_n(ras_n), .read_n(read_n), .ext_addr(ext_a), .data_bus16(data_bus16),
    .static_we_lower_n(we_n), .static_upper_n(up_n), .static_lower_a0(a0),
    .dram_we_lower_n(dpins[2]), .dram_upper_n(dpins[1]), .dram_cas_lower_n(dpins[0]));
  embc_ext_dev ext_dev (.clock(clock), .static_cs_n(cs_n), .stall_len(stall_len),
    .ext_wait_in_n(wait_n));

  // Free-running 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Strap must sit still for the whole reset so the filter settles
  task automatic do_reset(input logic s);
    @(negedge clock);
    resetn = 1'b0;
    strap = s;
    repeat (6) @(negedge clock);
    resetn = 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    {per_sel, per_write, per_addr, per_wdata} = {2'b11, a, v};
    @(negedge clock);
    per_sel = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge clock);
    {per_sel, per_write, per_addr} = {2'b10, a};
    rd_q.push_back(x);
    @(negedge clock);
    per_sel = 1'b0;
  endtask

  // Request held until the done pulse; negative note means a window
  task automatic acc(input logic [31:0] a, input logic w, input logic h, input int x);
    int n;
    n = 0;
    @(negedge clock);
    {acc_req, acc_write, acc_half, acc_addr} = {1'b1, w, h, a};
    acc_q.push_back(x);
    {snap, dsnap, rowgot} = {8'hff, 1'b0};
    while (acc_done !== 1'b1 && n < 64) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    acc_req = 1'b0;
  endtask

  // Watcher: oldest note against each read answer and each completion
  always @(posedge clock) begin
    if (rd_pend) chk(per_rdata, rd_q.pop_front());
    rd_pend <= per_sel && !per_write;
    if (acc_req && acc_done === 1'b1) begin
      e = acc_q.pop_front();
      if (e < 0) chk(32'(cyc >= -e && cyc <= 6 - e), 32'h1);
      else chk(cyc, e);
      cyc = 0;
    end else if (acc_req) cyc++;
    if (cs_n != 2'h3) snap <= snap & {data_bus16, we_n, up_n, a0};
    // Bank 3 pins while its row strobe is low; first such cycle shows the row
    if (!ras_n[1]) dsnap <= dsnap & {read_n, dpins};
    if (!ras_n[1] && !rowgot) {row_a, rowgot} <= {ext_a, 1'b1};
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    end_sim();
  end

  initial begin
    {per_sel, per_write, acc_req, acc_write, acc_half} = 5'h00;
    {per_addr, per_wdata, stall_len, acc_addr} = 56'h0;
    {resetn, strap, snap} = {2'b01, 4'hf};
    do_reset(1'b1);
    for (int i = 0; i < 7; i++) rd(ofs[i], rst[i]);
    for (int i = 0; i < 7; i++) begin
      d = 8'($random(seed));
      if (i == 4) d = d[0] ? 8'h11 : 8'h00;
      wr(ofs[i], d);
      rd(ofs[i], d & msk[i]);
    end
    wr(ofs[0], 8'h00);
    rd(ofs[0], 8'h00);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00);
    do_reset(1'b0);
    rd(ofs[0], 8'h0e);
    wr(ofs[2], 8'h00);
    wr(ofs[3], 8'h53);
    acc(32'h01000000, 1'b0, 1'b1, 6);
    acc(32'hfc000010, 1'b0, 1'b1, 4);
    acc(32'h00200000, 1'b0, 1'b1, 1);
    // off time on bank change and read to write
    wr(ofs[2], 8'h0d);
    acc(32'h01000000, 1'b0, 1'b1, 7);
    acc(32'h01000000, 1'b1, 1'b1, 9);
    acc(32'h01000002, 1'b1, 1'b1, 6);
    acc(32'h00000000, 1'b0, 1'b1, 7);
    wr(ofs[2], 8'h00);
    wr(ofs[3], 8'h70);
    stall_len = 8'h0a;
    acc(32'h01000000, 1'b0, 1'b1, 8);
    wr(ofs[1], 8'h02);
    acc(32'h01000000, 1'b0, 1'b1, -12);
    stall_len = 8'h00;
    // shared static pins per style and width
    wr(ofs[4], 8'h11);
    acc(32'h01000001, 1'b1, 1'b0, 8);
    repeat (3) @(negedge clock);
    chk(snap, 4'b1001);
    wr(ofs[4], 8'h00);
    acc(32'h01000001, 1'b1, 1'b0, 8);
    repeat (3) @(negedge clock);
    chk(snap, 4'b1101);
    wr(ofs[0], 8'h0d);
    acc(32'h01000001, 1'b1, 1'b0, 8);
    repeat (3) @(negedge clock);
    chk(snap, 4'b0011);
    wr(ofs[5], 8'h01);
    acc(32'h02000000, 1'b0, 1'b1, 3);
    acc(32'h02000004, 1'b0, 1'b1, 1);
    wr(ofs[6], 8'h0c);
    acc(32'h03000000, 1'b0, 1'b1, 3);
    acc(32'h03abcdef, 1'b0, 1'b1, 3);
    repeat (4) @(negedge clock);
    chk(row_a, 24'h001579);
    chk(dsnap, 4'b0100);
    end_sim();
  end
endmodule
